/* sfb_pkg.sv */
/*
 * Shared constants of the serial flash bus front end: opcodes, lane modes,
 * address field positions, reset values and the one-hot sequencer states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package sfb_pkg;
    // Address geometry
    localparam int ADDR_W       = 24;
    localparam int SECTOR_LSB   = 12;
    localparam int HALF_LSB     = 15;
    localparam int BLOCK_LSB    = 16;
    localparam int SECTOR_W     = 12;
    localparam int HALF_W       = 9;
    localparam int BLOCK_W      = 8;
    // Opcodes with wide data phases
    localparam logic [7:0] OP_DUAL_OUT  = 8'h3b;
    localparam logic [7:0] OP_DUAL_IO   = 8'hbb;
    localparam logic [7:0] OP_DUAL_ID   = 8'h92;
    localparam logic [7:0] OP_QUAD_OUT  = 8'h6b;
    localparam logic [7:0] OP_QUAD_IO   = 8'heb;
    localparam logic [7:0] OP_QUAD_WORD = 8'he7;
    localparam logic [7:0] OP_QUAD_ID   = 8'h94;
    localparam logic [7:0] OP_QUAD_PP   = 8'h32;
    // Counts and reset values
    localparam logic [7:0] BYTE_RST     = 8'h00;
    localparam logic [5:0] ADDR_BITS    = 6'h18;
    // Lane widths
    typedef enum logic [1:0] {
        SFB_LANE_ONE  = 2'h0,
        SFB_LANE_TWO  = 2'h1,
        SFB_LANE_FOUR = 2'h2
    } sfb_lane_type;
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        SFB_ST_OPCODE = 4'h1,
        SFB_ST_ADDR   = 4'h2,
        SFB_ST_DATA   = 4'h4,
        SFB_ST_DEAD   = 4'h8
    } sfb_state_type;
endpackage
`default_nettype wire

/* sfb_sync.sv */
/*
 * Two flip-flop level synchroniser for one bit.
 * Assumes the destination clock is free running; reset value is a constant.
 */
`default_nettype none
module sfb_sync (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic rst_val,
    input  wire logic d,
    output logic      q
);
    logic meta_q;
    logic meta_d;
    logic q_d;
    // Next values; first stage is read only by the second
    always_comb begin
        meta_d = meta_q;
        q_d    = q;
        if (!resetn) begin
            meta_d = rst_val;
            q_d    = rst_val;
        end else if (ce) begin
            meta_d = d;
            q_d    = meta_q;
        end
    end
    // Register stage
    always_ff @(posedge clk) begin
        meta_q <= meta_d;
        q      <= q_d;
    end
endmodule
`default_nettype wire

/* sfb_addr_decode.sv */
/*
 * Splits a captured 24-bit byte address into sector, half block and block.
 * Assumes the address is already stable in the caller's register.
 */
`default_nettype none
module sfb_addr_decode (
    input  wire logic [23:0] addr,
    output logic      [11:0] sector,
    output logic      [8:0]  half_block,
    output logic      [7:0]  block
);
    assign sector     = addr[sfb_pkg::SECTOR_LSB +: sfb_pkg::SECTOR_W];
    assign half_block = addr[sfb_pkg::HALF_LSB +: sfb_pkg::HALF_W];
    assign block      = addr[sfb_pkg::BLOCK_LSB +: sfb_pkg::BLOCK_W];
endmodule
`default_nettype wire

/* sfb_front_end.sv */
/*
 * Serial bus front end of a NOR flash: link logic on the serial clock,
 * status toward the core on ref_clk.
 * Assumes the core supplies quad_enable_bit, write_busy, por_active and read
 * data on ref_clk; the host drives serial clock, select and pause pin.
 */
`default_nettype none
module sfb_front_end (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        link_clk,
    input  wire logic        sel_n,
    input  wire logic        line_zero_in,
    input  wire logic        line_one_in,
    input  wire logic        line_two_in,
    input  wire logic        line_three_in,
    output logic             bidir_line_zero_out,
    output logic             bidir_line_zero_oe,
    output logic             bidir_line_one_out,
    output logic             bidir_line_one_oe,
    output logic             bidir_line_two_out,
    output logic             bidir_line_two_oe,
    output logic             bidir_line_three_out,
    output logic             bidir_line_three_oe,
    input  wire logic        quad_enable_bit,
    input  wire logic        por_active,
    input  wire logic        write_busy,
    input  wire logic [7:0]  rd_data,
    output logic             standby,
    output logic             paused,
    output logic [7:0]       last_opcode,
    output logic [11:0]      sector,
    output logic [8:0]       half_block,
    output logic [7:0]       block,
    output logic             opcode_strobe
);
    ////////////////////////////////////////////////////////////////////////
    // Lane width chosen from the opcode
    function automatic sfb_pkg::sfb_lane_type lane_of(input logic [7:0] op,
                                                      input logic       qe);
        sfb_pkg::sfb_lane_type l;
        l = sfb_pkg::SFB_LANE_ONE;
        if (op == sfb_pkg::OP_DUAL_OUT || op == sfb_pkg::OP_DUAL_IO ||
            op == sfb_pkg::OP_DUAL_ID) begin
            l = sfb_pkg::SFB_LANE_TWO;
        end else if (qe && (op == sfb_pkg::OP_QUAD_OUT || op == sfb_pkg::OP_QUAD_IO ||
                     op == sfb_pkg::OP_QUAD_WORD || op == sfb_pkg::OP_QUAD_ID ||
                     op == sfb_pkg::OP_QUAD_PP)) begin
            l = sfb_pkg::SFB_LANE_FOUR;
        end
        return l;
    endfunction

    // Writes never drive the lines
    function automatic logic is_write_op(input logic [7:0] op);
        return op == sfb_pkg::OP_QUAD_PP;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Core levels onto the link clock; they settle within the opcode
    logic qe_l;
    logic por_l;
    logic busy_r;
    logic armed_r;

    sfb_sync u_qe_l (
        .clk     (link_clk),
        .resetn  (resetn),
        .ce      (1'b1),
        .rst_val (1'b0),
        .d       (quad_enable_bit),
        .q       (qe_l)
    );
    sfb_sync u_por_l (
        .clk     (link_clk),
        .resetn  (resetn),
        .ce      (1'b1),
        .rst_val (1'b1),
        .d       (por_active),
        .q       (por_l)
    );

    ////////////////////////////////////////////////////////////////////////
    // Power-up arming on ref_clk: a select seen high arms the link
    logic sel_r;
    logic por_r;
    logic armed_q;
    logic armed_d;

    sfb_sync u_sel_r (
        .clk     (ref_clk),
        .resetn  (resetn),
        .ce      (ce),
        .rst_val (1'b0),
        .d       (sel_n),
        .q       (sel_r)
    );
    sfb_sync u_por_r (
        .clk     (ref_clk),
        .resetn  (resetn),
        .ce      (ce),
        .rst_val (1'b1),
        .d       (por_active),
        .q       (por_r)
    );
    sfb_sync u_busy_r (
        .clk     (ref_clk),
        .resetn  (resetn),
        .ce      (ce),
        .rst_val (1'b0),
        .d       (write_busy),
        .q       (busy_r)
    );

    // Next arming state
    always_comb begin
        armed_d = armed_q;
        if (por_r) begin
            armed_d = 1'b0;
        end else if (sel_r) begin
            armed_d = 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            armed_q <= 1'b0;
        end else if (ce) begin
            armed_q <= armed_d;
        end
    end

    // Arming crosses to the link as a level
    sfb_sync u_armed_l (
        .clk     (link_clk),
        .resetn  (resetn),
        .ce      (1'b1),
        .rst_val (1'b0),
        .d       (armed_q),
        .q       (armed_r)
    );

    // standby only when idle and no write runs
    assign standby = sel_r && !busy_r;

    ////////////////////////////////////////////////////////////////////////
    // Pause pin taken only while clock low, so a fall with clock high waits
    logic pause_n_pin;
    logic pause_lat;
    assign pause_n_pin = line_three_in;
    always_latch begin
        if (sel_n) begin
            pause_lat = 1'b0;
        end else if (!link_clk) begin
            pause_lat = !pause_n_pin && !qe_l;
        end
    end
    // pause only touches the link, never write_busy
    assign paused = pause_lat;

    ////////////////////////////////////////////////////////////////////////
    // Link sequencer; select high aborts at once, even in pause
    sfb_pkg::sfb_state_type state_q;
    sfb_pkg::sfb_state_type state_d;
    logic [7:0]  op_q;
    logic [7:0]  op_d;
    logic [23:0] addr_q;
    logic [23:0] addr_d;
    logic [5:0]  cnt_q;
    logic [5:0]  cnt_d;
    sfb_pkg::sfb_lane_type lane_q;
    sfb_pkg::sfb_lane_type lane_d;
    logic        op_tgl_q;
    logic        op_tgl_d;
    logic [3:0]  in_nib;
    logic        rise_ok_q;

    assign in_nib = {line_three_in, line_two_in, line_one_in, line_zero_in};

    // Next link values
    always_comb begin
        state_d  = state_q;
        op_d     = op_q;
        addr_d   = addr_q;
        cnt_d    = cnt_q;
        lane_d   = lane_q;
        op_tgl_d = op_tgl_q;
        if (!paused) begin
            case (state_q)
                sfb_pkg::SFB_ST_OPCODE: begin
                    op_d  = {op_q[6:0], line_zero_in};
                    cnt_d = cnt_q + 6'h1;
                    if (cnt_q == 6'h7) begin
                        if (por_l || !armed_r) begin
                            state_d = sfb_pkg::SFB_ST_DEAD;
                        end else begin
                            lane_d   = lane_of({op_q[6:0], line_zero_in}, qe_l);
                            state_d  = sfb_pkg::SFB_ST_ADDR;
                        end
                        cnt_d = 6'h0;
                    end
                end
                sfb_pkg::SFB_ST_ADDR: begin
                    // sampled on rising edge, msb first
                    case (lane_q)
                        sfb_pkg::SFB_LANE_FOUR: begin
                            addr_d = {addr_q[19:0], in_nib};
                            cnt_d  = cnt_q + 6'h4;
                        end
                        sfb_pkg::SFB_LANE_TWO: begin
                            addr_d = {addr_q[21:0], line_one_in, line_zero_in};
                            cnt_d  = cnt_q + 6'h2;
                        end
                        default: begin
                            addr_d = {addr_q[22:0], line_zero_in};
                            cnt_d  = cnt_q + 6'h1;
                        end
                    endcase
                    if (cnt_d >= sfb_pkg::ADDR_BITS) begin
                        state_d = sfb_pkg::SFB_ST_DATA;
                        cnt_d   = 6'h0;
                        // Event once the address is complete
                        op_tgl_d = !op_tgl_q;
                    end
                end
                sfb_pkg::SFB_ST_DATA: begin
                    cnt_d = cnt_q + 6'h1;
                end
                default: begin
                    state_d = sfb_pkg::SFB_ST_DEAD;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or posedge sel_n) begin
        if (sel_n) begin
            state_q <= sfb_pkg::SFB_ST_OPCODE;
            op_q    <= sfb_pkg::BYTE_RST;
            cnt_q   <= 6'h0;
            lane_q  <= sfb_pkg::SFB_LANE_ONE;
            rise_ok_q <= 1'b1;
        end else begin
            state_q <= state_d;
            op_q    <= op_d;
            cnt_q   <= cnt_d;
            lane_q  <= lane_d;
            rise_ok_q <= !paused;
        end
    end
    // Address and event toggle survive deselect for the core side
    always_ff @(posedge link_clk) begin
        if (!resetn) begin
            addr_q   <= 24'h000000;
            op_tgl_q <= 1'b0;
        end else begin
            addr_q   <= addr_d;
            op_tgl_q <= op_tgl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output shifter on the falling edge
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic       drive_q;
    logic       drive_d;
    logic       rd_fill;

    assign rd_fill = (state_q == sfb_pkg::SFB_ST_DATA) && (cnt_q[2:0] == 3'h0);

    // Next shifter values; core holds rd_data while selected
    always_comb begin
        sh_d    = sh_q;
        drive_d = 1'b0;
        if (state_q == sfb_pkg::SFB_ST_DATA && !is_write_op(op_q)) begin
            drive_d = 1'b1;
            case (lane_q)
                sfb_pkg::SFB_LANE_FOUR: sh_d = rd_fill ? rd_data : {sh_q[3:0], 4'h0};
                sfb_pkg::SFB_LANE_TWO:  sh_d = rd_fill ? rd_data : {sh_q[5:0], 2'h0};
                default:                sh_d = rd_fill ? rd_data : {sh_q[6:0], 1'b0};
            endcase
        end
    end
    always_ff @(negedge link_clk or posedge sel_n) begin
        if (sel_n) begin
            sh_q    <= sfb_pkg::BYTE_RST;
            drive_q <= 1'b0;
        end else if (rise_ok_q) begin // Latch and this edge race, so gate by the rise
            sh_q    <= sh_d;
            drive_q <= drive_d;
        end
    end

    // Line drive per lane width; float when paused or deselected
    always_comb begin
        bidir_line_zero_out  = 1'b0;
        bidir_line_one_out   = sh_q[7];
        bidir_line_two_out   = 1'b0;
        bidir_line_three_out = 1'b0;
        bidir_line_zero_oe   = 1'b0;
        bidir_line_one_oe    = 1'b0;
        bidir_line_two_oe    = 1'b0;
        bidir_line_three_oe  = 1'b0;
        if (drive_q && !paused && !sel_n) begin
            case (lane_q)
                sfb_pkg::SFB_LANE_FOUR: begin
                    {bidir_line_three_out, bidir_line_two_out} = sh_q[7:6];
                    {bidir_line_one_out, bidir_line_zero_out}  = sh_q[5:4];
                    bidir_line_zero_oe  = 1'b1;
                    bidir_line_one_oe   = 1'b1;
                    bidir_line_two_oe   = 1'b1;
                    bidir_line_three_oe = 1'b1;
                end
                sfb_pkg::SFB_LANE_TWO: begin
                    {bidir_line_one_out, bidir_line_zero_out} = sh_q[7:6];
                    bidir_line_zero_oe = 1'b1;
                    bidir_line_one_oe  = 1'b1;
                end
                default: begin
                    bidir_line_one_oe = 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Opcode event crosses by toggle; opcode and address are stable then
    logic tgl_r;
    logic tgl_seen_q;
    logic [7:0]  opc_q;
    logic [7:0]  opc_d;
    logic [23:0] addc_q;
    logic [23:0] addc_d;

    sfb_sync u_tgl_r (
        .clk     (ref_clk),
        .resetn  (resetn),
        .ce      (ce),
        .rst_val (1'b0),
        .d       (op_tgl_q),
        .q       (tgl_r)
    );

    // Capture on the toggle edge
    always_comb begin
        opc_d  = opc_q;
        addc_d = addc_q;
        if (tgl_r != tgl_seen_q) begin
            opc_d  = op_q;
            addc_d = addr_q;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            opc_q      <= sfb_pkg::BYTE_RST;
            addc_q     <= 24'h000000;
            tgl_seen_q <= 1'b0;
        end else if (ce) begin
            opc_q      <= opc_d;
            addc_q     <= addc_d;
            tgl_seen_q <= tgl_r;
        end
    end

    assign opcode_strobe = ce && (tgl_r != tgl_seen_q);
    assign last_opcode   = opc_q;

    sfb_addr_decode u_dec (
        .addr       (addc_q),
        .sector     (sector),
        .half_block (half_block),
        .block      (block)
    );
endmodule
`default_nettype wire

/* sfb_fe_props.sv */
/*
 * Port checks of the flash bus front end, all on the ref_clk domain.
 * Assumes a bind onto sfb_front_end with ce held high.
 */
`default_nettype none
module sfb_fe_props (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        sel_n,
    input wire logic        quad_enable_bit,
    input wire logic        por_active,
    input wire logic        write_busy,
    input wire logic        bidir_line_zero_oe,
    input wire logic        bidir_line_one_oe,
    input wire logic        bidir_line_two_oe,
    input wire logic        bidir_line_three_oe,
    input wire logic        standby,
    input wire logic        paused,
    input wire logic [7:0]  last_opcode,
    input wire logic [11:0] sector,
    input wire logic [8:0]  half_block,
    input wire logic [7:0]  block,
    input wire logic        opcode_strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic any_oe;
    // Any lane driving
    assign any_oe = bidir_line_zero_oe | bidir_line_one_oe | bidir_line_two_oe
                    | bidir_line_three_oe;
    default clocking dck @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    // Standby passes a synchroniser, so five samples cover its lag
    sequence s_sel_held;
        !sel_n [*5];
    endsequence
    sequence s_busy_held;
        write_busy [*5];
    endsequence
    sequence s_idle_held;
        (sel_n && !write_busy) [*5];
    endsequence
    ////////////////////////////////////////
    chk_desel_float: assert property (sel_n |-> !any_oe)
        else $error("lane driven while deselected");
    chk_pause_float: assert property (paused |-> !any_oe)
        else $error("lane driven while paused");
    chk_por_refuse: assert property (opcode_strobe |-> !por_active && !$past(por_active, 4))
        else $error("opcode accepted under power-on reset");
    chk_opcode_hold: assert property ($changed(last_opcode) |->
        (##[0:4] opcode_strobe) or $past(opcode_strobe) or $past(opcode_strobe, 2))
        else $error("opcode changed without strobe");
    chk_sel_active: assert property (s_sel_held |-> !standby)
        else $error("standby while selected");
    chk_write_active: assert property (s_busy_held |-> !standby)
        else $error("standby during internal write");
    chk_idle_standby: assert property (s_idle_held |-> standby)
        else $error("no standby when idle");
    chk_decode_nest: assert property (sector[11:3] == half_block && half_block[8:1] == block)
        else $error("sector, half block and block disagree");
    chk_dual_pair: assert property (bidir_line_zero_oe |-> bidir_line_one_oe)
        else $error("line zero driven without line one");
    chk_quad_pair: assert property (bidir_line_two_oe |-> bidir_line_three_oe && bidir_line_zero_oe)
        else $error("upper lanes driven apart");
    chk_quad_gate: assert property (bidir_line_two_oe |-> quad_enable_bit)
        else $error("four lanes without quad enable");
endmodule
`default_nettype wire

/* sfb_host_model.sv */
/*
 * Host serial controller: mode 0 clocking, one, two or four lanes.
 * Assumes the bench resolves every line level onto pin.
 */
`default_nettype none
module sfb_host_model (
    output var logic       link_clk,
    output var logic       sel_n,
    output var logic [3:0] h_out,
    output var logic [3:0] h_oe,
    input  wire logic [3:0] pin
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 32;
    // Select starts low, as a floating pin at power-up would
    initial begin
        link_clk = 1'b0;
        sel_n = 1'b0;
        h_out = 4'h0;
        h_oe = 4'h0;
    end
    // change while low, sample on rise, top group first
    task automatic xfer(input logic [31:0] v, input int nb, input int ln, input bit rd,
                        output logic [31:0] got);
        logic [3:0] m;
        m = (ln == 4) ? 4'hf : (ln == 2) ? 4'h3 : 4'h1;
        got = '0;
        h_oe = rd ? 4'h0 : m;
        for (int i = nb - ln; i >= 0; i -= ln) begin
            h_out = v[i +: 4] & m;
            #HALF link_clk = 1'b1;
            got = (got << ln) | ((ln == 1) ? {31'h0, pin[1]} : {28'h0, pin & m});
            #HALF link_clk = 1'b0;
        end
    endtask
    task automatic open_frame();
        sel_n = 1'b0;
        #HALF;
    endtask
    // select is raised between frames, lines released
    task automatic close_frame();
        #HALF sel_n = 1'b1;
        h_oe = 4'h0;
        #(4 * HALF);
    endtask
    // Deselected clocks carry arming to the link side
    task automatic wake();
        repeat (4) begin
            #HALF link_clk = 1'b1;
            #HALF link_clk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* serial_flash_bus_front_end_tb.sv */
/*
 * Self-checking bench of sfb_front_end driven by the host model.
 * Assumes sfb_pkg, the design files and the checker are compiled first.
 */
`default_nettype none
module serial_flash_bus_front_end_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk, resetn, qe, por, wbusy, pause_n, tog, seen_oe;
    logic        link_clk, sel_n, standby, paused, opcode_strobe;
    logic [3:0]  d_out, d_oe, h_out, h_oe, pin;
    logic [7:0]  rd_data, last_opcode, block;
    logic [11:0] sector;
    logic [8:0]  half_block;
    int          bad_count = 0, total_checks = 0, strobes = 0, exp_strobes = 0;
    // Released lines 0-1 toggle, line 2 pulled up, line 3 follows pause_n
    assign pin = (d_oe & d_out) | (~d_oe & h_oe & h_out)
                 | (~d_oe & ~h_oe & {pause_n, 1'b1, tog, ~tog});
    sfb_front_end dut_u (.ref_clk(ref_clk), .resetn(resetn), .ce(1'b1), .link_clk(link_clk),
        .sel_n(sel_n), .line_zero_in(pin[0]), .line_one_in(pin[1]), .line_two_in(pin[2]),
        .line_three_in(pin[3]), .bidir_line_zero_out(d_out[0]), .bidir_line_zero_oe(d_oe[0]),
        .bidir_line_one_out(d_out[1]), .bidir_line_one_oe(d_oe[1]),
        .bidir_line_two_out(d_out[2]), .bidir_line_two_oe(d_oe[2]),
        .bidir_line_three_out(d_out[3]), .bidir_line_three_oe(d_oe[3]),
        .quad_enable_bit(qe), .por_active(por), .write_busy(wbusy), .rd_data(rd_data),
        .standby(standby), .paused(paused), .last_opcode(last_opcode), .sector(sector),
        .half_block(half_block), .block(block), .opcode_strobe(opcode_strobe));
    sfb_host_model host_u (.link_clk(link_clk), .sel_n(sel_n), .h_out(h_out), .h_oe(h_oe),
        .pin(pin));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Count strobes and note any lane enable
    always @(posedge ref_clk) begin
        tog <= ~tog;
        if (opcode_strobe === 1'b1) strobes <= strobes + 1;
        if (d_oe !== 4'h0) seen_oe <= 1'b1;
    end
    ////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int ln,
                         input bit wr, input logic [7:0] rb, output logic [7:0] d);
        logic [31:0] t;
        tick(1);
        rd_data = rb;
        seen_oe = 1'b0;
        host_u.open_frame();
        host_u.xfer({24'h0, op}, 8, 1, 1'b0, t);
        host_u.xfer({8'h0, a}, 24, ln, 1'b0, t);
        host_u.xfer(32'h5a, 8, ln, !wr, t);
        d = t[7:0];
        host_u.close_frame();
        tick(4);
    endtask
    task automatic check_frame(input logic [7:0] op, input logic [23:0] a);
        exp_strobes++;
        cmp("strobes", 24'(exp_strobes), 24'(strobes));
        cmp("opcode", 24'(op), 24'(last_opcode));
        cmp("sector", 24'(a[23:12]), 24'(sector));
        cmp("half block", 24'(a[23:15]), 24'(half_block));
        cmp("block", 24'(a[23:16]), 24'(block));
    endtask
    ////////////////////////////////////////
    // select low since power-up never arms the link
    task automatic t_unarmed();
        logic [7:0] d;
        frame(8'h03, 24'h123456, 1, 1'b0, 8'h00, d);
        cmp("strobes", 24'h0, 24'(strobes));
        cmp("lanes", 24'h0, 24'(seen_oe));
        host_u.wake();
    endtask
    task automatic t_decode();
        logic [23:0] ad [5] = '{24'h000000, 24'h007fff, 24'h008000, 24'hfe7abc, 24'hffffff};
        logic [7:0] d;
        foreach (ad[i]) begin
            frame(8'h03, ad[i], 1, 1'b0, 8'h5a ^ 8'(i * 37), d);
            check_frame(8'h03, ad[i]);
            cmp("read", 24'(8'h5a ^ 8'(i * 37)), 24'(d));
        end
    endtask
    // every wide opcode, then quad without enable
    task automatic t_lanes();
        logic [7:0] op [8] = '{8'h3b, 8'hbb, 8'h92, 8'h6b, 8'heb, 8'he7, 8'h94, 8'h32};
        logic [7:0] d;
        tick(1);
        qe = 1'b1;
        foreach (op[i]) begin
            frame(op[i], {4'(i), 20'hc5f3c}, (i < 3) ? 2 : 4, op[i] == 8'h32, 8'h96 + 8'(i), d);
            check_frame(op[i], {4'(i), 20'hc5f3c});
            if (op[i] == 8'h32) cmp("write lanes", 24'h0, 24'(seen_oe));
            else cmp("wide read", 24'(8'h96 + 8'(i)), 24'(d));
        end
        host_u.open_frame();
        pause_n = 1'b0;
        #20 cmp("no pause", 24'h0, 24'(paused));
        pause_n = 1'b1;
        host_u.close_frame();
        tick(1);
        qe = 1'b0;
        frame(8'h6b, 24'h3c0ffe, 1, 1'b0, 8'h81, d);
        check_frame(8'h6b, 24'h3c0ffe);
        cmp("narrow read", 24'h81, 24'(d));
    endtask
    // pause mid-byte, clocks ignored, byte resumes
    task automatic t_pause();
        logic [31:0] t;
        tick(1);
        rd_data = 8'hb4;
        host_u.open_frame();
        host_u.xfer(32'h03, 8, 1, 1'b0, t);
        host_u.xfer(32'h00c123, 24, 1, 1'b0, t);
        host_u.xfer(32'h0, 4, 1, 1'b1, t);
        cmp("upper bits", 24'hb, 24'(t[3:0]));
        fork
            host_u.xfer(32'h0, 1, 1, 1'b1, t);
            begin
                #48 pause_n = 1'b0;
                #4 cmp("pause early", 24'h0, 24'(paused));
            end
        join
        cmp("bit three", 24'h0, 24'(t[0]));
        #4 cmp("pause", 24'h1, 24'(paused));
        host_u.xfer(32'hf, 4, 1, 1'b0, t);
        pause_n = 1'b1;
        #4 cmp("resume", 24'h0, 24'(paused));
        host_u.xfer(32'h0, 3, 1, 1'b1, t);
        cmp("lower bits", 24'h4, 24'(t[2:0]));
        host_u.close_frame();
        tick(4);
        check_frame(8'h03, 24'h00c123);
    endtask
    // deselect during pause drops the transfer
    task automatic t_abort();
        logic [31:0] t;
        logic [7:0] d;
        host_u.open_frame();
        host_u.xfer(32'h03, 8, 1, 1'b0, t);
        host_u.xfer(32'hab0, 12, 1, 1'b0, t);
        pause_n = 1'b0;
        #8 cmp("pause low clock", 24'h1, 24'(paused));
        host_u.close_frame();
        pause_n = 1'b1;
        frame(8'h0b, 24'h5a5a5a, 1, 1'b0, 8'h3c, d);
        check_frame(8'h0b, 24'h5a5a5a);
        cmp("read", 24'h3c, 24'(d));
    endtask
    // standby against select and internal write
    task automatic t_standby();
        tick(5);
        cmp("standby idle", 24'h1, 24'(standby));
        wbusy = 1'b1;
        tick(5);
        cmp("standby write", 24'h0, 24'(standby));
        wbusy = 1'b0;
        host_u.open_frame();
        tick(5);
        cmp("standby selected", 24'h0, 24'(standby));
        host_u.close_frame();
    endtask
    task automatic t_por();
        logic [7:0] d;
        tick(1);
        por = 1'b1;
        frame(8'h9f, 24'h777000, 1, 1'b0, 8'h11, d);
        cmp("por strobes", 24'(exp_strobes), 24'(strobes));
        cmp("por opcode", 24'h0b, 24'(last_opcode));
        por = 1'b0;
        tick(4);
        host_u.wake();
        frame(8'h03, 24'h777000, 1, 1'b0, 8'h11, d);
        check_frame(8'h03, 24'h777000);
    endtask
    ////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        qe = 1'b0;
        por = 1'b0;
        wbusy = 1'b0;
        pause_n = 1'b1;
        rd_data = 8'h00;
        tog = 1'b0;
        seen_oe = 1'b0;
        fork
            tick(4);
            host_u.wake();
        join
        resetn = 1'b1;
        t_unarmed();
        t_decode();
        t_lanes();
        t_pause();
        t_abort();
        t_standby();
        t_por();
        stop_test();
    end
    // Run needs about 46 us; a hang is cut well after
    initial begin
        #400000;
        bad_count++;
        stop_test();
    end
endmodule
bind sfb_front_end sfb_fe_props chk_u (.ref_clk(ref_clk), .resetn(resetn), .sel_n(sel_n),
    .quad_enable_bit(quad_enable_bit), .por_active(por_active), .write_busy(write_busy),
    .bidir_line_zero_oe(bidir_line_zero_oe), .bidir_line_one_oe(bidir_line_one_oe),
    .bidir_line_two_oe(bidir_line_two_oe), .bidir_line_three_oe(bidir_line_three_oe),
    .standby(standby), .paused(paused), .last_opcode(last_opcode), .sector(sector),
    .half_block(half_block), .block(block), .opcode_strobe(opcode_strobe));
`default_nettype wire
